/* hw/ufs_flash_dev.sv */
// Flash end: word array, serial registers, self-timed program and erase.
//
// Functional notes
// - 512 words, 9-bit address 000h to 1FFh
// - Low half sector zero, high half one
// - Erase clears one whole sector only
// - User logic erases before programming a sector
// - Erase leaves the other sector untouched
// - Words are sixteen bits at most
// - Program and erase timed by ring oscillator
// - Ring clock divided by four exported
// - Exported clock rate fixed, not programmable
// - Request starts complete internal algorithm
// - User logic holds request until busy drops
// - Busy drops only when operation finished
// - Single read and stream read supported
// - Address clock with select low increments
// - Separate serial address and data signals
// - Address shifter 9 bits, data 16 bits
// - Scan port may program and read too
// - Inputs may come from global lines
`timescale 1ns/10ps
`include "ufs_defines.svh"
module ufs_flash_dev
   import ufs_pkg::*;
#(
   parameter int RING_PRESCALE = `UFS_RING_PRESCALE,
   parameter int PROG_TICKS = (`UFS_PROG_TIME_NS
      + `UFS_CLK_PERIOD_NS * RING_PRESCALE - 1)
      / (`UFS_CLK_PERIOD_NS * RING_PRESCALE),
   parameter int ERASE_TICKS = (`UFS_ERASE_TIME_NS
      + `UFS_CLK_PERIOD_NS * RING_PRESCALE - 1)
      / (`UFS_CLK_PERIOD_NS * RING_PRESCALE),
   parameter bit RING_OUT_EN = 1'b1
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   ufs_link_if.dev link,
   input wire logic scanEnable,
   input wire logic [`UFS_ADDR_W-1:0] scanAddr,
   input wire logic [`UFS_DATA_W-1:0] scanData,
   input wire logic scanWriteReq,
   input wire logic scanWipeReq,
   output logic [`UFS_DATA_W-1:0] scanRdData,
   output logic scanBusy
);

   // -------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------
   if (RING_PRESCALE < 1 || RING_PRESCALE > 65536)
      $error("ufs_flash_dev: RING_PRESCALE must be 1 to 65536");
   if (PROG_TICKS < 1 || ERASE_TICKS < 1)
      $error("ufs_flash_dev: operation times must be at least one tick");
   if (ERASE_TICKS >= (1 << `UFS_TIMER_W) ||
       PROG_TICKS >= (1 << `UFS_TIMER_W))
      $error("ufs_flash_dev: operation time exceeds timer width");

   // -------------------------------------------------------------
   // Storage and state
   // -------------------------------------------------------------
   // array size
   logic [`UFS_DATA_W-1:0] flashArray [`UFS_WORDS];
   logic [`UFS_ADDR_W-1:0] addrReg_ff;
   logic [`UFS_DATA_W-1:0] dataReg_ff;
   logic [`UFS_ADDR_W-1:0] opAddr_ff;
   logic [`UFS_DATA_W-1:0] opData_ff;
   logic [`UFS_TIMER_W-1:0] timer_ff;
   logic [`UFS_TIMER_W-1:0] nxt_timer;
   logic [15:0] prescale_ff;
   logic ringTick;
   logic [1:0] ringDiv_ff;
   logic busy_ff;
   logic dataOut_ff;
   logic ringOut_ff;
   logic [`UFS_DATA_W-1:0] scanRd_ff;
   logic reqWrite;
   logic reqWipe;
   logic [`UFS_ADDR_W-1:0] reqAddr;
   logic [`UFS_DATA_W-1:0] reqData;
   logic timerDone;
   ufs_dev_state_t state_ff;

   // Sector index of a word address.
   function automatic logic sector_of(input logic [`UFS_ADDR_W-1:0] a);
      sector_of = a[`UFS_SECTOR_BIT];
   endfunction : sector_of

   // -------------------------------------------------------------
   // Ring oscillator model
   // -------------------------------------------------------------
   // The ring runs free from reset; every timed step counts its ticks,
   // so operation time is counted in ticks of RING_PRESCALE clk_sys cycles each.
   // ring tick source
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         prescale_ff <= 16'h0000;
      else if (ringTick)
         prescale_ff <= 16'h0000;
      else
         prescale_ff <= prescale_ff + 16'h0001;
   end

   assign ringTick = (prescale_ff == 16'(RING_PRESCALE - 1));

   // The exported clock has a fixed ratio; nothing can reprogram it.
   // divide by four
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         ringDiv_ff <= 2'h0;
         ringOut_ff <= 1'b0;
      end
      else if (ringTick)
      begin
         ringDiv_ff <= ringDiv_ff + 2'h1;
         ringOut_ff <= RING_OUT_EN & ringDiv_ff[1];
      end
   end

   // -------------------------------------------------------------
   // Request selection
   // -------------------------------------------------------------
   // Link inputs are on clk_sys already, whether routed or global.
   // unsynchronised inputs
   assign reqWrite = scanEnable ? scanWriteReq : link.writeReq;
   assign reqWipe = scanEnable ? scanWipeReq : link.wipeReq;
   assign reqAddr = scanEnable ? scanAddr : addrReg_ff;
   assign reqData = scanEnable ? scanData : dataReg_ff;
   assign timerDone = (timer_ff == '0) && ringTick;

   // -------------------------------------------------------------
   // Address shift register
   // -------------------------------------------------------------
   // Frozen while busy so the latched target cannot be disturbed.
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         addrReg_ff <= '0;
      else if (link.addrRegisterClock && !busy_ff)
      begin
         if (link.addrLoadSelect)
            addrReg_ff <= {addrReg_ff[`UFS_ADDR_W-2:0], link.addrSerialIn};
         else
            addrReg_ff <= addrReg_ff + 9'h001;
      end
   end

   // -------------------------------------------------------------
   // Data shift register
   // -------------------------------------------------------------
   // With shift select low a data clock loads the addressed word;
   // with it high the word moves out MSB first while new bits enter.
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         dataReg_ff <= '0;
         dataOut_ff <= 1'b0;
      end
      else if (link.dataRegisterClock && !busy_ff)
      begin
         if (link.dataShiftSelect)
         begin
            dataReg_ff <= {dataReg_ff[`UFS_DATA_W-2:0], link.dataSerialIn};
            dataOut_ff <= dataReg_ff[`UFS_DATA_W-2];
         end
         else
         begin
            dataReg_ff <= flashArray[addrReg_ff];
            dataOut_ff <= flashArray[addrReg_ff][`UFS_DATA_W-1];
         end
      end
   end

   // -------------------------------------------------------------
   // Program and erase sequencer
   // -------------------------------------------------------------
   // self-timed algorithm
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         state_ff <= UFS_DEV_IDLE;
         busy_ff <= 1'b0;
         opAddr_ff <= '0;
         opData_ff <= '0;
      end
      else
      begin
         unique case (state_ff)
            UFS_DEV_IDLE:
            begin
               if (reqWipe)
               begin
                  state_ff <= UFS_DEV_WIPE;
                  busy_ff <= 1'b1;
                  opAddr_ff <= reqAddr;
               end
               else if (reqWrite)
               begin
                  state_ff <= UFS_DEV_PROG;
                  busy_ff <= 1'b1;
                  opAddr_ff <= reqAddr;
                  opData_ff <= reqData;
               end
            end
            UFS_DEV_PROG, UFS_DEV_WIPE:
            begin
               if (timerDone)
               begin
                  state_ff <= UFS_DEV_DONE;
                  busy_ff <= 1'b0;
               end
            end
            UFS_DEV_DONE:
            begin
               // A still-held request must not start a second operation.
               if (!reqWrite && !reqWipe)
                  state_ff <= UFS_DEV_IDLE;
            end
         endcase
      end
   end

   // Operation timer, loaded at request and counted in ring ticks.
   always_comb
   begin
      nxt_timer = timer_ff;
      if (state_ff == UFS_DEV_IDLE)
         nxt_timer = reqWipe ? `UFS_TIMER_W'(ERASE_TICKS - 1)
                             : `UFS_TIMER_W'(PROG_TICKS - 1);
      else if (ringTick && timer_ff != '0)
         nxt_timer = timer_ff - `UFS_TIMER_W'(1);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         timer_ff <= '0;
      else
         timer_ff <= nxt_timer;
   end

   // -------------------------------------------------------------
   // Array update
   // -------------------------------------------------------------
   // Programming can only clear bits, as real flash cells do; the user
   // logic must wipe the sector first to get the word it wrote.
   // relies on prior erase
   always_ff @(posedge clk_sys)
   begin
      if (timerDone && state_ff == UFS_DEV_PROG)
         flashArray[opAddr_ff] <= flashArray[opAddr_ff] & opData_ff;
      else if (timerDone && state_ff == UFS_DEV_WIPE)
      begin
         for (int i = 0; i < `UFS_SECTOR_WORDS; i++)
            flashArray[{sector_of(opAddr_ff), 8'(i)}] <= `UFS_ERASED_WORD;
      end
   end

   // Scan read port, registered so the output stays glitch free.
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         scanRd_ff <= '0;
      else
         scanRd_ff <= flashArray[scanAddr];
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign link.busy = busy_ff;
   assign link.dataSerialOut = dataOut_ff;
   assign link.ringClockOut = ringOut_ff;
   assign scanRdData = scanRd_ff;
   assign scanBusy = busy_ff;

endmodule : ufs_flash_dev

/* hw/ufs_defines.svh */
// Constants shared by both ends of the user flash serial link.
`ifndef UFS_DEFINES_SVH
`define UFS_DEFINES_SVH

// -------------------------------------------------------------
// Array geometry
// -------------------------------------------------------------
`define UFS_ADDR_W 9
`define UFS_DATA_W 16
`define UFS_WORDS 512
`define UFS_SECTOR_BIT 8
`define UFS_SECTOR_WORDS 256
`define UFS_ERASED_WORD 16'hffff
`define UFS_ADDR_LAST 9'h1ff

// -------------------------------------------------------------
// Timing
// -------------------------------------------------------------
`define UFS_CLK_PERIOD_NS 100
`define UFS_RING_PRESCALE 1
`define UFS_RING_OUT_DIV 4
`define UFS_PROG_TIME_NS 100000
`define UFS_ERASE_TIME_NS 500000000
`define UFS_TIMER_W 24

`endif

/* hw/ufs_pkg.sv */
// Types shared by both ends of the user flash serial link.
package ufs_pkg;

   // Sequencer states of the flash end.
   typedef enum logic [1:0]
   {
      UFS_DEV_IDLE = 2'b00,
      UFS_DEV_PROG = 2'b01,
      UFS_DEV_WIPE = 2'b10,
      UFS_DEV_DONE = 2'b11
   } ufs_dev_state_t;

   // Commands accepted by the user logic end.
   typedef enum logic [1:0]
   {
      UFS_OP_READ = 2'b00,
      UFS_OP_NEXT = 2'b01,
      UFS_OP_WRITE = 2'b10,
      UFS_OP_WIPE = 2'b11
   } ufs_op_t;

   // Sequencer states of the user logic end.
   typedef enum logic [2:0]
   {
      UFS_HST_IDLE = 3'b000,
      UFS_HST_ADDR = 3'b001,
      UFS_HST_STEP = 3'b010,
      UFS_HST_LOAD = 3'b011,
      UFS_HST_DATA = 3'b100,
      UFS_HST_HOLD = 3'b101
   } ufs_hst_state_t;

endpackage : ufs_pkg

/* hw/ufs_link_if.sv */
// Serial link between the flash block and the fabric user logic.
`timescale 1ns/10ps
interface ufs_link_if;
   logic addrSerialIn;
   logic addrLoadSelect;
   logic addrRegisterClock;
   logic dataSerialIn;
   logic dataShiftSelect;
   logic dataRegisterClock;
   logic writeReq;
   logic wipeReq;
   logic busy;
   logic dataSerialOut;
   logic ringClockOut;

   modport dev
   (
      input addrSerialIn,
      input addrLoadSelect,
      input addrRegisterClock,
      input dataSerialIn,
      input dataShiftSelect,
      input dataRegisterClock,
      input writeReq,
      input wipeReq,
      output busy,
      output dataSerialOut,
      output ringClockOut
   );

   modport host
   (
      output addrSerialIn,
      output addrLoadSelect,
      output addrRegisterClock,
      output dataSerialIn,
      output dataShiftSelect,
      output dataRegisterClock,
      output writeReq,
      output wipeReq,
      input busy,
      input dataSerialOut,
      input ringClockOut
   );
endinterface : ufs_link_if

/* hw/ufs_flash_host.sv */
// User logic end: turns parallel commands into the serial flash protocol.
`timescale 1ns/10ps
`include "ufs_defines.svh"
module ufs_flash_host
   import ufs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   ufs_link_if.host link,
   input wire logic cmdValid,
   input wire ufs_op_t cmdOp,
   input wire logic [`UFS_ADDR_W-1:0] cmdAddr,
   input wire logic [`UFS_DATA_W-1:0] cmdData,
   output logic cmdReady,
   output logic rdValid,
   output logic [`UFS_DATA_W-1:0] rdData
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   ufs_hst_state_t state_ff;
   ufs_op_t op_ff;
   logic [`UFS_ADDR_W-1:0] addrSh_ff;
   logic [`UFS_DATA_W-1:0] txSh_ff;
   logic [`UFS_DATA_W-1:0] rx_ff;
   logic [4:0] count_ff;
   logic seenBusy_ff;
   logic aClk_ff, aSel_ff, aBit_ff;
   logic dClk_ff, dSel_ff, dBit_ff;
   logic wrReq_ff, wipeReq_ff;
   logic ready_ff, rdValid_ff;

   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   // Each serial strobe is a one-cycle pulse; both ends share clk_sys,
   // so strobes may follow back to back.
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         state_ff <= UFS_HST_IDLE;
         op_ff <= UFS_OP_READ;
         addrSh_ff <= '0;
         txSh_ff <= '0;
         rx_ff <= '0;
         count_ff <= 5'h00;
         seenBusy_ff <= 1'b0;
         {aClk_ff, aSel_ff, aBit_ff} <= 3'h0;
         {dClk_ff, dSel_ff, dBit_ff} <= 3'h0;
         {wrReq_ff, wipeReq_ff} <= 2'h0;
         ready_ff <= 1'b0;
         rdValid_ff <= 1'b0;
      end
      else
      begin
         aClk_ff <= 1'b0;
         dClk_ff <= 1'b0;
         rdValid_ff <= 1'b0;
         unique case (state_ff)
            UFS_HST_IDLE:
            begin
               ready_ff <= 1'b1;
               if (cmdValid && ready_ff)
               begin
                  ready_ff <= 1'b0;
                  op_ff <= cmdOp;
                  addrSh_ff <= cmdAddr;
                  txSh_ff <= cmdData;
                  count_ff <= 5'h00;
                  state_ff <= (cmdOp == UFS_OP_NEXT) ? UFS_HST_STEP
                                                     : UFS_HST_ADDR;
               end
            end
            UFS_HST_ADDR:
            begin
               aClk_ff <= 1'b1;
               aSel_ff <= 1'b1;
               aBit_ff <= addrSh_ff[`UFS_ADDR_W-1];
               addrSh_ff <= {addrSh_ff[`UFS_ADDR_W-2:0], 1'b0};
               count_ff <= count_ff + 5'h01;
               if (count_ff == 5'(`UFS_ADDR_W - 1))
               begin
                  count_ff <= 5'h00;
                  unique case (op_ff)
                     UFS_OP_WRITE: state_ff <= UFS_HST_DATA;
                     UFS_OP_WIPE: state_ff <= UFS_HST_HOLD;
                     default: state_ff <= UFS_HST_LOAD;
                  endcase
               end
            end
            UFS_HST_STEP:
            begin
               aClk_ff <= 1'b1;
               aSel_ff <= 1'b0;
               state_ff <= UFS_HST_LOAD;
            end
            UFS_HST_LOAD:
            begin
               dClk_ff <= 1'b1;
               dSel_ff <= 1'b0;
               state_ff <= UFS_HST_DATA;
            end
            UFS_HST_DATA:
            begin
               // Capture the bit the flash shows before this shift.
               // Writes skip the capture so the last read word stands.
               if (count_ff != 5'h00 && op_ff != UFS_OP_WRITE)
                  rx_ff <= {rx_ff[`UFS_DATA_W-2:0], link.dataSerialOut};
               if (count_ff == 5'(`UFS_DATA_W))
               begin
                  count_ff <= 5'h00;
                  if (op_ff == UFS_OP_WRITE)
                     state_ff <= UFS_HST_HOLD;
                  else
                  begin
                     rdValid_ff <= 1'b1;
                     state_ff <= UFS_HST_IDLE;
                  end
               end
               else
               begin
                  dClk_ff <= 1'b1;
                  dSel_ff <= 1'b1;
                  dBit_ff <= txSh_ff[`UFS_DATA_W-1];
                  txSh_ff <= {txSh_ff[`UFS_DATA_W-2:0], 1'b0};
                  count_ff <= count_ff + 5'h01;
               end
            end
            UFS_HST_HOLD:
            begin
               wrReq_ff <= (op_ff == UFS_OP_WRITE);
               wipeReq_ff <= (op_ff == UFS_OP_WIPE);
               if (link.busy)
                  seenBusy_ff <= 1'b1;
               else if (seenBusy_ff)
               begin
                  seenBusy_ff <= 1'b0;
                  {wrReq_ff, wipeReq_ff} <= 2'h0;
                  state_ff <= UFS_HST_IDLE;
               end
            end
            default:
               state_ff <= UFS_HST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign link.addrRegisterClock = aClk_ff;
   assign link.addrLoadSelect = aSel_ff;
   assign link.addrSerialIn = aBit_ff;
   assign link.dataRegisterClock = dClk_ff;
   assign link.dataShiftSelect = dSel_ff;
   assign link.dataSerialIn = dBit_ff;
   assign link.writeReq = wrReq_ff;
   assign link.wipeReq = wipeReq_ff;
   assign cmdReady = ready_ff;
   assign rdValid = rdValid_ff;
   assign rdData = rx_ff;

endmodule : ufs_flash_host

/* sim/ufs_link_props.sv */
// Concurrent checks on the serial link between the two flash ends.
`timescale 1ns/10ps
module ufs_link_props
#(
   parameter int PROG_TICKS = 5,
   parameter int ERASE_TICKS = 20
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic addrSerialIn,
   input wire logic addrLoadSelect,
   input wire logic addrRegisterClock,
   input wire logic dataSerialIn,
   input wire logic dataShiftSelect,
   input wire logic dataRegisterClock,
   input wire logic writeReq,
   input wire logic wipeReq,
   input wire logic busy,
   input wire logic dataSerialOut,
   input wire logic ringClockOut
);
   int busyLen_ff;
   logic wipeRun_ff;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // Busy length and the kind of job that raised it.
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         busyLen_ff <= 0;
         wipeRun_ff <= 1'b0;
      end
      else
      begin
         busyLen_ff <= busy ? busyLen_ff + 1 : 0;
         if (!busy)
            wipeRun_ff <= wipeReq; // Latched so the fall can be judged.
      end
   end

   // -------------------------------------------------------------
   // Sequences and assertions
   // -------------------------------------------------------------
   sequence addrShiftNine;
      (addrRegisterClock && addrLoadSelect)[*8] ##1
         (addrRegisterClock && addrLoadSelect);
   endsequence

   sequence loadWord;
      dataRegisterClock && !dataShiftSelect;
   endsequence

   a_busy_rise_prompt: assert property (
      $rose(writeReq || wipeReq) |=> busy)
      else $error("Busy did not rise after a request.");
   a_busy_has_cause: assert property (
      $rose(busy) |-> $past(writeReq || wipeReq))
      else $error("Busy rose without a request.");
   a_busy_full_length: assert property (
      $fell(busy) |-> busyLen_ff == (wipeRun_ff ? ERASE_TICKS : PROG_TICKS))
      else $error("Busy length does not match the job timer.");
   a_request_held: assert property (
      busy |-> (writeReq || wipeReq))
      else $error("Request dropped while busy.");
   a_request_release: assert property (
      $fell(busy) |-> ##[0:2] !(writeReq || wipeReq))
      else $error("Request not released after busy fell.");
   a_one_job_only: assert property (
      !(writeReq && wipeReq))
      else $error("Program and erase requested together.");
   a_ring_div_four: assert property (
      $rose(ringClockOut) |=> ringClockOut ##1 !ringClockOut
         ##1 !ringClockOut ##1 ringClockOut)
      else $error("Exported clock is not a divide by four.");
   a_addr_nine_bits: assert property (
      addrShiftNine |=> !addrRegisterClock)
      else $error("Address shift longer than nine bits.");
   a_stream_then_load: assert property (
      addrRegisterClock && !addrLoadSelect |-> ##[1:2] loadWord)
      else $error("Increment not followed by a word load.");
endmodule : ufs_link_props

/* sim/ufs_flash_tb_top.sv */
// Testbench joining the user logic end to the flash end.
`timescale 1ns/10ps
module ufs_flash_tb_top
   import ufs_pkg::*;
;
   localparam int PROG_T = 5;
   localparam int ERASE_T = 20;
   localparam int CYC_LIMIT = 5000; // Whole run needs about 500 cycles.
   logic clk_sys = 1'b0;
   logic reset_n;
   logic cmdValid;
   ufs_op_t cmdOp;
   logic [8:0] cmdAddr;
   logic [8:0] scanAddr;
   logic [15:0] cmdData;
   logic cmdReady;
   logic rdValid;
   logic [15:0] rdData;
   logic [15:0] scanRdData;
   logic scanBusy;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;

   ufs_link_if link();

   ufs_flash_dev #(.PROG_TICKS(PROG_T), .ERASE_TICKS(ERASE_T))
      ufs_flash_dev_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .link(link), .scanEnable(1'b0), .scanAddr(scanAddr),
      .scanData(16'h0000), .scanWriteReq(1'b0), .scanWipeReq(1'b0),
      .scanRdData(scanRdData), .scanBusy(scanBusy));

   ufs_flash_host ufs_flash_host_inst (.clk_sys(clk_sys),
      .reset_n(reset_n), .link(link), .cmdValid(cmdValid),
      .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData));

   ufs_link_props #(.PROG_TICKS(PROG_T), .ERASE_TICKS(ERASE_T))
      ufs_link_props_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .addrSerialIn(link.addrSerialIn),
      .addrLoadSelect(link.addrLoadSelect),
      .addrRegisterClock(link.addrRegisterClock),
      .dataSerialIn(link.dataSerialIn),
      .dataShiftSelect(link.dataShiftSelect),
      .dataRegisterClock(link.dataRegisterClock),
      .writeReq(link.writeReq), .wipeReq(link.wipeReq),
      .busy(link.busy), .dataSerialOut(link.dataSerialOut),
      .ringClockOut(link.ringClockOut));

   // -------------------------------------------------------------
   // Clock, hang guard and helper tasks
   // -------------------------------------------------------------
   // Clock at 10 MHz.
   always #50 clk_sys = ~clk_sys;

   // A stuck handshake must still end in the closing report.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == CYC_LIMIT)
      begin
         failures++;
         complete_run();
      end
   end

   task automatic check16(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
            seen, exp);
      end
   endtask : check16

   // Each command task starts and ends one small delay after a rising edge.
   task automatic wait_ready;
      while (cmdReady !== 1'b1)
      begin
         @(posedge clk_sys);
         #1;
      end
   endtask : wait_ready

   task automatic run_cmd(input ufs_op_t op, input logic [8:0] addr,
      input logic [15:0] data);
      wait_ready();
      cmdValid = 1'b1;
      cmdOp = op;
      cmdAddr = addr;
      cmdData = data;
      @(posedge clk_sys);
      #1;
      cmdValid = 1'b0;
   endtask : run_cmd

   task automatic read_chk(input ufs_op_t op, input logic [8:0] addr,
      input logic [15:0] exp);
      run_cmd(op, addr, 16'h0000);
      while (rdValid !== 1'b1)
      begin
         @(posedge clk_sys);
         #1;
      end
      check16(rdData, exp);
   endtask : read_chk

   task automatic complete_run;
      $display("Compared %0d values, %0d mismatches", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   // Erase both sectors, program across the boundary, then stream.
   initial
   begin
      reset_n = 1'b0;
      cmdValid = 1'b0;
      cmdOp = UFS_OP_READ;
      cmdAddr = 9'h000;
      cmdData = 16'h0000;
      scanAddr = 9'h000;
      repeat (5) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      run_cmd(UFS_OP_WIPE, 9'h000, 16'h0000);
      run_cmd(UFS_OP_WIPE, 9'h100, 16'h0000);
      read_chk(UFS_OP_READ, 9'h000, 16'hffff);
      read_chk(UFS_OP_READ, 9'h1ff, 16'hffff);
      run_cmd(UFS_OP_WRITE, 9'h0ff, 16'h1234);
      run_cmd(UFS_OP_WRITE, 9'h100, 16'habcd);
      run_cmd(UFS_OP_WRITE, 9'h1ff, 16'h5a5a);
      read_chk(UFS_OP_READ, 9'h0ff, 16'h1234);
      read_chk(UFS_OP_NEXT, 9'h000, 16'habcd);
      read_chk(UFS_OP_NEXT, 9'h000, 16'hffff);
      read_chk(UFS_OP_READ, 9'h1ff, 16'h5a5a);
      run_cmd(UFS_OP_WRITE, 9'h1ff, 16'h0f0f);
      // Request rises 27 edges after the take; busy spans edges 28 to 33.
      repeat (30) @(posedge clk_sys);
      #1;
      check16({15'h0000, scanBusy}, 16'h0001);
      wait_ready();
      check16(rdData, 16'h5a5a);
      read_chk(UFS_OP_READ, 9'h1ff, 16'h0a0a);
      run_cmd(UFS_OP_WIPE, 9'h0ab, 16'h0000);
      read_chk(UFS_OP_READ, 9'h0ff, 16'hffff);
      read_chk(UFS_OP_READ, 9'h100, 16'habcd);
      scanAddr = 9'h1ff;
      repeat (2) @(posedge clk_sys);
      #1;
      check16(scanRdData, 16'h0a0a);
      check16({15'h0000, scanBusy}, 16'h0000);
      complete_run();
   end
endmodule : ufs_flash_tb_top
